//--- jtx_link_tx.sv
// transmit link layers: transport, scrambler, line coding, lmfc, registers
`timescale 1ns/10ps
`default_nettype none
module jtx_link_tx #(
  parameter int M  = 8,
  parameter int S  = 1,
  parameter int NP = 8
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [M*S*NP-1:0]     frameIn,
  output logic                       frameTake,
  input  wire logic                  sysref,
  input  wire logic                  syncN,
  input  wire jtx_pkg::jtx_axi_req_t axiReq,
  output var jtx_pkg::jtx_axi_rsp_t  axiRsp,
  output var jtx_pkg::jtx_lane_t     lane,
  output logic                       fecEnable
);
  if (M * S * NP != jtx_pkg::FRAME_BITS) begin : g_chk
    $error("samples must fill the frame word");
  end

  typedef struct packed {
    jtx_pkg::jtx_st_t st;
    logic        rd;
    logic [57:0] lfsr;
    logic [1:0]  sysSync;
    logic [1:0]  syncSync;
    logic        sysPrev;
    logic [2:0]  octIdx;
    logic [7:0]  frmIdx;
    logic [7:0]  lemcIdx;
    logic        lmfcPulse;
    logic [1:0]  mfCnt;
    logic [7:0]  ramp;
    logic [63:0] frame;
    logic        linkEn;
    logic        scrambleEn;
    logic        enc66;
    logic        fecEn;
    logic [1:0]  mode;
    logic [7:0]  kM1;
    logic        awHave;
    logic [7:0]  awAddr;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [9:0]  sym;
    logic        symValid;
    logic [7:0]  curOct;
    logic        curK;
    logic [55:0] blk;
    logic [65:0] blkOut;
    logic        blkValid;
  } jtx_state_t;

  jtx_state_t q_r;
  jtx_state_t q_nxt;

  // =====================================
  // helpers
  function automatic logic [121:0] scrambleBits(input logic [57:0] st, input logic [63:0] d,
                                           input int nb, input int ta, input int tb);
    logic [57:0] s;
    logic [63:0] o;
    logic        b;
    s = st;
    o = d;
    for (int i = 63; i >= 0; i--) begin
      if (i >= 64 - nb) begin
        b = d[i] ^ s[ta-1] ^ s[tb-1];
        o[i] = b;
        s = {s[56:0], b};
      end
    end
    return {s, o};
  endfunction : scrambleBits

  function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic       r;
    logic [4:0] x;
    logic [2:0] y;
    x = d[4:0];
    y = d[7:5];
    r = rd;
    if (k) begin
      c6 = jtx_pkg::K28_6B;
      c4 = jtx_pkg::K28_4B[4*y +: 4];
      if (r) c6 = ~c6;
      r = ~r;
      if (r) c4 = ~c4;
      if ($countones(c4) != 2) r = ~r;
    end else begin
      c6 = jtx_pkg::TBL6[6*x +: 6];
      if (r && ($countones(c6) != 3 || x == 5'h07)) c6 = ~c6;
      if ($countones(c6) != 3) r = ~r;
      c4 = jtx_pkg::TBL4[4*y +: 4];
      if (y == 3'h7 && ((!r && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                        (r && (x == 5'h0B || x == 5'h0D || x == 5'h0E)))) c4 = jtx_pkg::ALT7;
      if (r && ($countones(c4) != 2 || y == 3'h3)) c4 = ~c4;
      if ($countones(c4) != 2) r = ~r;
    end
    return {r, c6, c4};
  endfunction : enc8b10b

  logic [3:0]  fOf;
  logic [2:0]  fLast;
  logic [11:0] kTot;
  logic        kValid;
  logic        kOk;
  logic        sysRise;
  logic        syncOk;
  logic        wrapNow;
  logic        mfStart;
  logic        lastOct;
  logic [7:0]  frameOct;

  assign fOf      = jtx_pkg::jtx_oct_per_frame(q_r.mode);
  assign fLast    = 3'(fOf - 4'h1);
  assign kTot     = ({4'h0, q_r.kM1} + 12'h1) * {8'h0, fOf};
  assign kValid   = kTot >= jtx_pkg::KF_MIN && kTot <= jtx_pkg::KF_MAX;
  assign kOk      = q_r.enc66 | kValid;
  assign sysRise  = q_r.sysSync[1] & ~q_r.sysPrev;
  assign syncOk   = q_r.syncSync[1];
  assign lastOct  = q_r.octIdx == fLast;
  assign wrapNow  = lastOct && q_r.frmIdx == q_r.kM1;
  assign mfStart  = q_r.octIdx == 3'h0 && q_r.frmIdx == 8'h0;
  assign frameOct = q_r.frame[{3'h7 - q_r.octIdx, 3'h0} +: 8];

  // =====================================
  // bus answers and outputs
  assign axiRsp = '{awready: ~q_r.awHave & ~q_r.bvalid, wready: ~q_r.wHave & ~q_r.bvalid,
                    bvalid: q_r.bvalid, bresp: q_r.bresp, arready: ~q_r.rvalid,
                    rvalid: q_r.rvalid, rdata: q_r.rdata, rresp: q_r.rresp};
  assign lane = '{sym: q_r.sym, symValid: q_r.symValid, blk: q_r.blkOut, blkValid: q_r.blkValid};
  assign frameTake = lastOct;
  assign fecEnable = q_r.fecEn;

  always_comb begin
    logic [7:0]   oct;
    logic         isK;
    logic         emit;
    logic         doScramble;
    logic [121:0] sr;
    logic [10:0]  ec;
    logic [31:0]  rd;
    oct = frameOct;
    isK = 1'b0;
    emit = 1'b1;
    doScramble = 1'b0;
    sr = '0;
    ec = '0;
    rd = '0;
    q_nxt = q_r;
    // =====================================
    // synchronisers and lmfc / lemc
    q_nxt.sysSync = {q_r.sysSync[0], sysref};
    q_nxt.syncSync = {q_r.syncSync[0], syncN};
    q_nxt.sysPrev = q_r.sysSync[1];
    q_nxt.octIdx = lastOct ? 3'h0 : q_r.octIdx + 3'h1;
    if (lastOct) begin
      q_nxt.frmIdx = (q_r.frmIdx == q_r.kM1) ? 8'h0 : q_r.frmIdx + 8'h1;
      q_nxt.frame = frameIn;
    end
    q_nxt.lemcIdx = q_r.lemcIdx + 8'h1;
    q_nxt.lmfcPulse = q_r.enc66 ? q_r.lemcIdx == 8'hFF : wrapNow;
    if (sysRise) begin
      q_nxt.octIdx = 3'h0;
      q_nxt.frmIdx = 8'h0;
      q_nxt.lemcIdx = 8'h0;
      q_nxt.lmfcPulse = 1'b0;
    end
    // =====================================
    // link sequence
    case (q_r.st)
      jtx_pkg::ST_IDLE: begin
        emit = 1'b0;
        if (q_r.linkEn) q_nxt.st = q_r.enc66 ? jtx_pkg::ST_DATA : jtx_pkg::ST_CGS;
      end
      jtx_pkg::ST_CGS: begin
        oct = jtx_pkg::K28_5;
        isK = 1'b1;
        if (syncOk) q_nxt.st = jtx_pkg::ST_WAIT;
      end
      jtx_pkg::ST_WAIT: begin
        oct = jtx_pkg::K28_5;
        isK = 1'b1;
        if (!syncOk) begin
          q_nxt.st = jtx_pkg::ST_CGS;
        end else if (wrapNow && !sysRise) begin
          q_nxt.st = jtx_pkg::ST_ILAS;
          q_nxt.mfCnt = 2'h0;
          q_nxt.ramp = 8'h0;
        end
      end
      jtx_pkg::ST_ILAS: begin
        if (mfStart) begin
          oct = jtx_pkg::K28_0;
          isK = 1'b1;
        end else if (wrapNow) begin
          oct = jtx_pkg::K28_3;
          isK = 1'b1;
        end else begin
          oct = q_r.ramp;
          q_nxt.ramp = q_r.ramp + 8'h1;
        end
        if (wrapNow) begin
          q_nxt.mfCnt = q_r.mfCnt + 2'h1;
          if (q_r.mfCnt == jtx_pkg::ILAS_LAST) q_nxt.st = jtx_pkg::ST_DATA;
        end
        if (!syncOk) q_nxt.st = jtx_pkg::ST_CGS;
      end
      jtx_pkg::ST_DATA: begin
        doScramble = q_r.enc66 | q_r.scrambleEn;
        if (!q_r.enc66 && !syncOk) q_nxt.st = jtx_pkg::ST_CGS;
      end
      default: q_nxt.st = jtx_pkg::ST_IDLE;
    endcase
    if (!q_r.linkEn || !kOk) q_nxt.st = jtx_pkg::ST_IDLE;
    // =====================================
    // scrambling and line coding
    q_nxt.symValid = 1'b0;
    q_nxt.blkValid = 1'b0;
    if (!q_r.enc66) begin
      if (doScramble) begin
        // self-synchronous: no seed passes to the receiver
        sr = scrambleBits(q_r.lfsr, {oct, 56'h0}, 8, jtx_pkg::TAP8_A, jtx_pkg::TAP8_B);
        oct = sr[63:56];
        q_nxt.lfsr = sr[121:64];
      end
      if (emit) begin
        ec = enc8b10b(oct, isK, q_r.rd);
        q_nxt.rd = ec[10];
        q_nxt.sym = ec[9:0];
        q_nxt.symValid = 1'b1;
      end
    end else if (q_r.st == jtx_pkg::ST_DATA) begin
      q_nxt.blk = {q_r.blk[47:0], oct};
      if (q_r.lemcIdx[2:0] == 3'h7) begin
        sr = scrambleBits(q_r.lfsr, {q_r.blk, oct}, 64, jtx_pkg::TAP66_A, jtx_pkg::TAP66_B);
        q_nxt.lfsr = sr[121:64];
        q_nxt.blkOut = {jtx_pkg::SH_DATA, sr[63:0]};
        q_nxt.blkValid = 1'b1;
      end
    end
    q_nxt.curOct = oct;
    q_nxt.curK = isK & emit;
    // =====================================
    // register slave
    if (axiReq.awvalid && axiRsp.awready) begin
      q_nxt.awHave = 1'b1;
      q_nxt.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      q_nxt.wHave = 1'b1;
      q_nxt.wData = axiReq.wdata;
      q_nxt.wStrb = axiReq.wstrb;
    end
    if (q_r.awHave && q_r.wHave) begin
      q_nxt.awHave = 1'b0;
      q_nxt.wHave = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = jtx_pkg::RSP_OKAY;
      case ({q_r.awAddr[7:2], 2'h0})
        jtx_pkg::REG_CTRL: begin
          if (q_r.wStrb[0]) begin
            q_nxt.linkEn = q_r.wData[jtx_pkg::CTRL_LINK];
            q_nxt.scrambleEn = q_r.wData[jtx_pkg::CTRL_SCRAMBLE];
            q_nxt.enc66 = q_r.wData[jtx_pkg::CTRL_E66];
            q_nxt.fecEn = q_r.wData[jtx_pkg::CTRL_FEC];
            q_nxt.mode = q_r.wData[jtx_pkg::CTRL_MODE +: 2];
          end
        end
        jtx_pkg::REG_KCFG: begin
          if (q_r.wStrb[0]) q_nxt.kM1 = q_r.wData[7:0];
        end
        jtx_pkg::REG_STAT: q_nxt.bresp = jtx_pkg::RSP_OKAY;
        default: q_nxt.bresp = jtx_pkg::RSP_SLVERR;
      endcase
    end
    if (q_r.bvalid && axiReq.bready) q_nxt.bvalid = 1'b0;
    if (axiReq.arvalid && axiRsp.arready) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = jtx_pkg::RSP_OKAY;
      case ({axiReq.araddr[7:2], 2'h0})
        jtx_pkg::REG_CTRL: begin
          rd[jtx_pkg::CTRL_LINK] = q_r.linkEn;
          rd[jtx_pkg::CTRL_SCRAMBLE] = q_r.scrambleEn;
          rd[jtx_pkg::CTRL_E66] = q_r.enc66;
          rd[jtx_pkg::CTRL_FEC] = q_r.fecEn;
          rd[jtx_pkg::CTRL_MODE +: 2] = q_r.mode;
        end
        jtx_pkg::REG_KCFG: rd[7:0] = q_r.kM1;
        jtx_pkg::REG_STAT: begin
          rd[jtx_pkg::STAT_ST +: 3] = q_r.st;
          rd[jtx_pkg::STAT_KOK] = kValid;
          rd[jtx_pkg::STAT_SYNC] = syncOk;
          rd[jtx_pkg::STAT_FRM +: 8] = q_r.frmIdx;
        end
        default: q_nxt.rresp = jtx_pkg::RSP_SLVERR;
      endcase
      q_nxt.rdata = rd;
    end else if (q_r.rvalid && axiReq.rready) begin
      q_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
      q_r.kM1 <= jtx_pkg::RST_KM1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // =====================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_SYSREF_RESET: assert property (sysRise |=> q_r.octIdx == 3'h0 && q_r.frmIdx == 8'h0
                                     && q_r.lemcIdx == 8'h0) else $error("lmfc not reset by sysref");
  AST_LMFC_WRAP: assert property (q_r.lmfcPulse && !q_r.enc66 |-> mfStart)
    else $error("lmfc pulse off multiframe start");
  AST_ILAS_START: assert property (q_r.st == jtx_pkg::ST_WAIT && syncOk && wrapNow && !sysRise
                                   && q_r.linkEn && kOk |=> q_r.st == jtx_pkg::ST_ILAS
                                   ##1 q_r.curK && q_r.curOct == jtx_pkg::K28_0)
    else $error("alignment sequence not started on lmfc edge");
  AST_ILAS_PLAIN: assert property (q_r.st == jtx_pkg::ST_ILAS && !mfStart && !wrapNow
                                   |=> q_r.curOct == $past(q_r.ramp))
    else $error("alignment data altered");
  AST_CGS_COMMA: assert property (!syncOk && q_r.st != jtx_pkg::ST_IDLE && !q_r.enc66
                                  && q_r.linkEn && kOk |=> q_r.st == jtx_pkg::ST_CGS)
    else $error("sync request not answered");
  AST_PLAIN_DATA: assert property (q_r.st == jtx_pkg::ST_DATA && !q_r.enc66 && !q_r.scrambleEn
                                   |=> q_r.curOct == $past(frameOct))
    else $error("data changed with scrambling off");
  AST_SYNC_HDR: assert property (q_r.blkValid |-> q_r.blkOut[65:64] == jtx_pkg::SH_DATA)
    else $error("bad sync header");
  AST_BALANCE: assert property (q_r.symValid |-> $countones(q_r.sym) inside {4, 5, 6})
    else $error("character out of balance");
  AST_K_RANGE: assert property (!kValid && !q_r.enc66 |=> q_r.st == jtx_pkg::ST_IDLE)
    else $error("link runs with illegal K");
  AST_ILAS_END: assert property (q_r.st == jtx_pkg::ST_ILAS && wrapNow && q_r.mfCnt == 2'h3
                                 && syncOk && q_r.linkEn && kOk |=> q_r.st == jtx_pkg::ST_DATA)
    else $error("alignment sequence length wrong");
endmodule : jtx_link_tx
`default_nettype wire

//--- jtx_pkg.sv
// constants and types of the transmit link layers
`default_nettype none
package jtx_pkg;
  // =====================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_KCFG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam int CTRL_LINK = 0;
  localparam int CTRL_SCRAMBLE = 1;
  localparam int CTRL_E66  = 2;
  localparam int CTRL_FEC  = 3;
  localparam int CTRL_MODE = 4;
  localparam int STAT_ST   = 0;
  localparam int STAT_KOK  = 3;
  localparam int STAT_SYNC = 4;
  localparam int STAT_FRM  = 8;
  localparam logic [7:0] RST_KM1 = 8'h1F;
  localparam logic [1:0] RSP_OKAY = 2'h0;
  localparam logic [1:0] RSP_SLVERR = 2'h2;
  // =====================================
  // link constants
  localparam int FRAME_BITS = 64;
  localparam logic [11:0] KF_MIN = 12'h011;
  localparam logic [11:0] KF_MAX = 12'h400;
  localparam logic [1:0] ILAS_LAST = 2'h3;
  localparam logic [7:0] K28_0 = 8'h1C;
  localparam logic [7:0] K28_3 = 8'h7C;
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [1:0] SH_DATA = 2'h1;
  localparam int TAP8_A = 14;
  localparam int TAP8_B = 15;
  localparam int TAP66_A = 39;
  localparam int TAP66_B = 58;
  // 5b/6b and 3b/4b codes for negative running disparity
  localparam logic [191:0] TBL6 = {
    6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
    6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27};
  localparam logic [31:0] TBL4 = 32'hE6ADC59B;
  localparam logic [3:0] ALT7 = 4'h7;
  localparam logic [5:0] K28_6B = 6'h0F;
  localparam logic [31:0] K28_4B = 32'h7050C00B;

  typedef enum logic [2:0] {ST_IDLE, ST_CGS, ST_WAIT, ST_ILAS, ST_DATA} jtx_st_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } jtx_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } jtx_axi_rsp_t;

  typedef struct packed {
    logic [9:0]  sym;
    logic        symValid;
    logic [65:0] blk;
    logic        blkValid;
  } jtx_lane_t;

  // octets per frame for each transport mode
  function automatic logic [3:0] jtx_oct_per_frame(input logic [1:0] mode);
    case (mode)
      2'h0: return 4'h1;
      2'h1: return 4'h2;
      2'h2: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction : jtx_oct_per_frame
endpackage : jtx_pkg
`default_nettype wire

//--- jtx_rx_model.sv
// receiver model: sync handshake and lane character monitor
`timescale 1ns/10ps
`default_nettype none
module jtx_rx_model (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire jtx_pkg::jtx_lane_t lane,
  input  wire logic               resync,
  output logic                    syncN,
  output var int                  nComma,
  output var int                  nR,
  output var int                  nA,
  output var int                  rToA,
  output var int                  rToR,
  output var int                  badDisp
);
  logic hold;
  logic isComma;
  logic isR;
  logic isA;
  int   run;
  int   disp;
  int   ones;
  int   cyc;
  int   lastR;
  assign ones    = $countones(lane.sym);
  assign isComma = lane.symValid && (lane.sym == 10'h0FA || lane.sym == 10'h305);
  assign isR     = lane.symValid && (lane.sym == 10'h0F4 || lane.sym == 10'h30B);
  assign isA     = lane.symValid && (lane.sym == 10'h0F3 || lane.sym == 10'h30C);
  // only the sync level goes back, never a scrambler seed
  assign syncN   = !hold;
  // ==========================================
  // handshake and character statistics
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold    <= 1'h1;
      run     <= 0;
      disp    <= 0;
      cyc     <= 0;
      lastR   <= 0;
      nComma  <= 0;
      nR      <= 0;
      nA      <= 0;
      rToA    <= 0;
      rToR    <= 0;
      badDisp <= 0;
    end else begin
      cyc <= cyc + 1;
      if (resync) begin
        hold <= 1'h1;
        run  <= 0;
        disp <= 0;
      end else if (lane.symValid) begin
        run  <= isComma ? run + 1 : 0;
        disp <= disp + ones - 5;
        // release after four commas in a row
        if (run >= 4) begin
          hold <= 1'h0;
        end
        if (ones < 4 || ones > 6 || disp + ones - 5 > 1 || disp + ones - 5 < -1) begin
          badDisp <= badDisp + 1;
        end
      end
      if (isComma) begin
        nComma <= nComma + 1;
      end
      if (isR) begin
        nR    <= nR + 1;
        rToR  <= cyc - lastR;
        lastR <= cyc;
      end
      if (isA) begin
        nA   <= nA + 1;
        rToA <= cyc - lastR;
      end
    end
  end
endmodule : jtx_rx_model
`default_nettype wire

//--- serial_converter_link_tx_layers_test.sv
// self-checking bench for the transmit link layers
`timescale 1ns/10ps
`default_nettype none
module serial_converter_link_tx_layers_test;
  localparam int KF = 32;
  logic                  clk;
  logic                  rst_n;
  logic [63:0]           frameIn;
  logic                  frameTake;
  logic                  sysref;
  logic                  syncN;
  logic                  resync;
  logic                  fecEnable;
  jtx_pkg::jtx_axi_req_t req;
  jtx_pkg::jtx_axi_rsp_t rsp;
  jtx_pkg::jtx_lane_t    lane;
  int                    nComma, nR, nA, rToA, rToR, badDisp;
  int                    nFail = 0;
  int                    comparisons = 0;
  int                    cycles = 0;
  int                    nBlk, bad, same, last, prev;
  logic [31:0]           rd;
  logic [1:0]            rr;
  logic [1:0]            kMode [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [7:0]            kCfg [6]  = '{8'h0F, 8'h10, 8'hFF, 8'hFF, 8'h7F, 8'h80};
  logic                  kOk [6]   = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};

  jtx_link_tx #(.M(8), .S(1), .NP(8)) uut (.clk(clk), .rst_n(rst_n), .frameIn(frameIn), .frameTake(frameTake),
    .sysref(sysref), .syncN(syncN), .axiReq(req), .axiRsp(rsp), .lane(lane), .fecEnable(fecEnable));
  jtx_rx_model rx (.clk(clk), .rst_n(rst_n), .lane(lane), .resync(resync), .syncN(syncN), .nComma(nComma),
    .nR(nR), .nA(nA), .rToA(rToA), .rToR(rToR), .badDisp(badDisp));

  // ==========================================
  // report and compare
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      nFail++;
    end
  endtask : chk

  // ==========================================
  // register bus master
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awOk;
    logic wOk;
    awOk = 1'h0;
    wOk  = 1'h0;
    req.awaddr  <= a;
    req.awvalid <= 1'h1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.wvalid  <= 1'h1;
    req.bready  <= 1'h1;
    while (!(awOk && wOk)) begin
      @(posedge clk);
      if (!awOk && rsp.awready === 1'h1) begin
        awOk = 1'h1;
        req.awvalid <= 1'h0;
      end
      if (!wOk && rsp.wready === 1'h1) begin
        wOk = 1'h1;
        req.wvalid <= 1'h0;
      end
    end
    while (rsp.bvalid !== 1'h1) @(posedge clk);
    r = rsp.bresp;
    req.bready <= 1'h0;
    @(posedge clk);
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    req.araddr  <= a;
    req.arvalid <= 1'h1;
    req.rready  <= 1'h1;
    @(posedge clk);
    while (rsp.arready !== 1'h1) @(posedge clk);
    req.arvalid <= 1'h0;
    while (rsp.rvalid !== 1'h1) @(posedge clk);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'h0;
    @(posedge clk);
  endtask : axiRead

  task automatic readChk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    axiRead(a, rd, rr);
    chk("read data", exp, rd & msk);
    chk("read resp", {30'h0, (a > 8'h08) ? jtx_pkg::RSP_SLVERR : jtx_pkg::RSP_OKAY}, {30'h0, rr});
  endtask : readChk

  task automatic waitState(input logic [2:0] s);
    rd = 32'h0;
    for (int i = 0; i < 300 && rd[2:0] !== s; i++) begin
      axiRead(jtx_pkg::REG_STAT, rd, rr);
    end
    chk("link state", {29'h0, s}, {29'h0, rd[2:0]});
  endtask : waitState

  // ==========================================
  // clock, timeout and test sequence
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nFail++;
      conclude();
    end
  end

  initial begin
    rst_n   = 1'h0;
    req     = '0;
    sysref  = 1'h0;
    resync  = 1'h0;
    frameIn = 64'h0123456789ABCDEF;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    readChk(jtx_pkg::REG_CTRL, 32'h0, 32'hFFFFFFFF);
    readChk(jtx_pkg::REG_KCFG, 32'h1F, 32'hFFFFFFFF);
    readChk(jtx_pkg::REG_STAT, 32'h0, 32'h7);
    readChk(8'h0C, 32'h0, 32'hFFFFFFFF);
    axiWrite(8'h0C, 32'h1, rr);
    chk("write resp", {30'h0, jtx_pkg::RSP_SLVERR}, {30'h0, rr});
    for (int i = 0; i < 6; i++) begin
      axiWrite(jtx_pkg::REG_CTRL, {26'h0, kMode[i], 4'h0}, rr);
      axiWrite(jtx_pkg::REG_KCFG, {24'h0, kCfg[i]}, rr);
      readChk(jtx_pkg::REG_STAT, {28'h0, kOk[i], 3'h0}, 32'h8);
    end
    axiWrite(jtx_pkg::REG_CTRL, 32'h31, rr);
    same = 0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      same += frameTake;
    end
    chk("frame take", 32'h3, same);
    readChk(jtx_pkg::REG_STAT, 32'h0, 32'h7);
    // bring-up in 8b10b with scrambling on
    axiWrite(jtx_pkg::REG_KCFG, 32'h1F, rr);
    axiWrite(jtx_pkg::REG_CTRL, 32'h03, rr);
    waitState(jtx_pkg::ST_DATA);
    chk("commas", 32'h1, {31'h0, nComma >= 4});
    chk("start chars", 32'h4, nR);
    chk("end chars", 32'h4, nA);
    chk("start to end", KF - 1, rToA);
    chk("multiframe", KF, rToR);
    chk("disparity", 32'h0, badDisp);
    readChk(jtx_pkg::REG_STAT, 32'h10, 32'h10);
    // sysref realigns the frame counter
    sysref <= 1'h1;
    repeat (4) @(posedge clk);
    sysref <= 1'h0;
    repeat (8) @(posedge clk);
    axiRead(jtx_pkg::REG_STAT, rd, rr);
    chk("frame index", 32'h1, {31'h0, rd[15:8] >= 8'h06 && rd[15:8] <= 8'h10});
    // resync from data
    prev = nComma;
    resync <= 1'h1;
    @(posedge clk);
    resync <= 1'h0;
    repeat (12) @(posedge clk);
    waitState(jtx_pkg::ST_DATA);
    chk("commas again", 32'h1, {31'h0, nComma >= prev + 4});
    chk("start chars again", 32'h8, nR);
    // 64b66b with scramble bit clear and sync held low
    resync <= 1'h1;
    @(posedge clk);
    resync <= 1'h0;
    axiWrite(jtx_pkg::REG_CTRL, 32'h0D, rr);
    repeat (2) @(posedge clk);
    chk("fec flag", 32'h1, {31'h0, fecEnable});
    repeat (40) @(posedge clk);
    readChk(jtx_pkg::REG_STAT, 32'h04, 32'h17);
    nBlk = 0;
    bad  = 0;
    same = 0;
    last = 0;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      #1;
      if (lane.blkValid === 1'h1) begin
        nBlk++;
        bad  += (lane.blk[65:64] !== jtx_pkg::SH_DATA) + (nBlk > 1 && i - last != 8);
        same += (lane.blk[63:0] === {8{frameIn[63:56]}});
        last = i;
      end
    end
    chk("blocks", 32'h8, nBlk);
    chk("block header", 32'h0, bad);
    chk("unscrambled blocks", 32'h0, same);
    @(posedge clk);
    axiWrite(jtx_pkg::REG_CTRL, 32'h05, rr);
    repeat (2) @(posedge clk);
    chk("fec off", 32'h0, {31'h0, fecEnable});
    readChk(jtx_pkg::REG_CTRL, 32'h05, 32'hFF);
    // back to 8b10b with scrambling off
    axiWrite(jtx_pkg::REG_CTRL, 32'h01, rr);
    waitState(jtx_pkg::ST_DATA);
    chk("start chars plain", 32'hC, nR);
    chk("plain data", 32'h1, {31'h0, lane.sym == 10'h1D4 || lane.sym == 10'h22B});
    chk("disparity plain", 32'h0, badDisp);
    conclude();
  end
endmodule : serial_converter_link_tx_layers_test
`default_nettype wire
